// file: rtl/ms_delay.v
// Millisecond delay counter for the sequencer.
// Assumes one clock domain and a restart that the owner raises whenever
// the interval must start over.
`timescale 1ns/1ns
`include "seq_defs.vh"
module ms_delay #(
  parameter CLKS_PER_MS = `SEQ_CLKS_PER_MS,
  parameter PRESCALE_W  = `SEQ_PRESCALE_W,
  parameter MS_W        = `SEQ_MS_W
) (
  input  wire            sys_clk_i,
  input  wire            rst_n_i,
  input  wire            restart_i,
  input  wire [MS_W-1:0] target_i,
  output wire            done_o
);

  // Last prescaler count, cut to the prescaler width on purpose
  localparam integer          PRE_LAST_I = CLKS_PER_MS - 1;
  localparam [PRESCALE_W-1:0] PRE_LAST   = PRE_LAST_I[PRESCALE_W-1:0];
  localparam [MS_W-1:0]       MS_MAX   = {MS_W{1'b1}};

  reg [PRESCALE_W-1:0] pre_reg;
  reg [MS_W-1:0]       ms_reg;

  // Prescaler and ms count both clear on restart, so a full interval
  // always follows the restart; the count saturates rather than wraps
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_reg <= {PRESCALE_W{1'b0}};
      ms_reg  <= {MS_W{1'b0}};
    end else if (restart_i) begin
      pre_reg <= {PRESCALE_W{1'b0}};
      ms_reg  <= {MS_W{1'b0}};
    end else if (pre_reg == PRE_LAST) begin
      pre_reg <= {PRESCALE_W{1'b0}};
      if (ms_reg != MS_MAX)
        ms_reg <= ms_reg + {{(MS_W-1){1'b0}}, 1'b1};
    end else begin
      pre_reg <= pre_reg + {{(PRESCALE_W-1){1'b0}}, 1'b1};
    end
  end

  assign done_o = (ms_reg >= target_i);

endmodule // ms_delay

// file: rtl/power_reset_seq.v
// Board power and reset sequencer: rail enables, clock generator
// power-down pins, processor resets and boot configuration pins.
// Assumes all inputs are synchronous to sys_clk_i and the power-good
// inputs are high while their rail is valid.
`timescale 1ns/1ns
`include "seq_defs.vh"

// Overview of operation
// (R1) After payload and auxiliary power arrive, all processor outputs stay low.
// (R2) 5 V and 2.5 V rails enable after 3.3 V aux stable 10 ms.
// (R3) Adaptive core rail enables after 5 V and 2.5 V stable 5 ms.
// (R4) Fixed 1.0 V core rail enables 5 ms after adaptive core enable.
// (R5) 1.8 V I/O rail enables after fixed core rail stable 5 ms.
// (R6) After 1.8 V stable 5 ms, unlock 1.8 V outputs, start clock gens.
// (R7) 1.5 V memory rail enables 5 ms after clock generators start.
// (R8) 0.75 V termination rail enables after 1.5 V stable 5 ms.
// (R9) Warm reset releases after 0.75 V stable and PLLs locked 5 ms.
// (R10) Boot configuration drives onto GPIO from warm reset release onward.
// (R11) Power-on reset releases 5 ms after warm reset release.
// (R12) Full reset releases 5 ms after power-on reset release.
// (R13) Boot GPIO pins are released 1 ms after full reset release.
// (R14) Power failure or payload loss asserts full and power-on reset at once.
// (R15) 5 ms later, lock 1.8 V outputs and power down clock generators.
// (R16) Finally all main rails switch off together, 5 V excepted.
// (R17) Four user LEDs and one user switch are passed to and from software.
// (R18) System power good only when every monitored rail is good.
// (R19) Stable means power good held; interval restarts when it drops.
module power_reset_seq #(
  parameter CLKS_PER_MS = `SEQ_CLKS_PER_MS,
  parameter BOOT_W      = 16
) (
  input  wire              sys_clk_i,
  input  wire              rst_n_i,
  input  wire              payload_power_i,
  input  wire              power_fail_i,
  input  wire              aux_3v3_rail_pg_i,
  input  wire              rail_5v_pg_i,
  input  wire              rail_2v5_pg_i,
  input  wire              adaptive_core_rail_pg_i,
  input  wire              fixed_core_rail_pg_i,
  input  wire              io_1v8_rail_pg_i,
  input  wire              memory_1v5_rail_pg_i,
  input  wire              termination_rail_pg_i,
  input  wire              clkgen_pll_locked_i,
  input  wire [BOOT_W-1:0] boot_cfg_i,
  input  wire [3:0]        user_led_i,
  input  wire              user_switch_i,
  output reg               rail_5v_en_o,
  output reg               rail_2v5_en_o,
  output reg               adaptive_core_rail_en_o,
  output reg               fixed_core_rail_en_o,
  output reg               io_1v8_rail_en_o,
  output reg               memory_1v5_rail_en_o,
  output reg               termination_rail_en_o,
  output reg               outputs_1v8_unlocked_o,
  output reg               clkgen_powerdown_n_o,
  output reg               warm_reset_n_o,
  output reg               power_on_reset_n_o,
  output reg               full_reset_n_o,
  output reg               nmi_n_o,
  output reg [BOOT_W-1:0]  boot_cfg_o,
  output reg               boot_cfg_oe_n_o,
  output reg               system_power_good_o,
  output reg [3:0]         user_led_o,
  output reg               user_switch_o
);

  // State bit positions, in sequence order so ranges decode outputs
  localparam integer I_IDLE  = 0;
  localparam integer I_AUX   = 1;
  localparam integer I_R5V   = 2;
  localparam integer I_ACORE = 3;
  localparam integer I_FCORE = 4;
  localparam integer I_IO    = 5;
  localparam integer I_CLK   = 6;
  localparam integer I_MEM   = 7;
  localparam integer I_TERM  = 8;
  localparam integer I_WARM  = 9;
  localparam integer I_POR   = 10;
  localparam integer I_FULL  = 11;
  localparam integer I_RUN   = 12;
  localparam integer I_PDRST = 13;
  localparam integer I_PDCLK = 14;
  localparam integer I_PDOFF = 15;

  localparam [15:0] S_IDLE  = 16'h0001;
  localparam [15:0] S_AUX   = 16'h0002;
  localparam [15:0] S_R5V   = 16'h0004;
  localparam [15:0] S_ACORE = 16'h0008;
  localparam [15:0] S_FCORE = 16'h0010;
  localparam [15:0] S_IO    = 16'h0020;
  localparam [15:0] S_CLK   = 16'h0040;
  localparam [15:0] S_MEM   = 16'h0080;
  localparam [15:0] S_TERM  = 16'h0100;
  localparam [15:0] S_WARM  = 16'h0200;
  localparam [15:0] S_POR   = 16'h0400;
  localparam [15:0] S_FULL  = 16'h0800;
  localparam [15:0] S_RUN   = 16'h1000;
  localparam [15:0] S_PDRST = 16'h2000;
  localparam [15:0] S_PDCLK = 16'h4000;
  localparam [15:0] S_PDOFF = 16'h8000;

  // Sequence state and the wait that the delay counter is timing
  reg  [15:0]          state_reg;
  reg  [15:0]          state_next;
  reg                  watch_pg;
  reg  [`SEQ_MS_W-1:0] target;
  wire                 delay_done;
  wire                 fail;
  wire                 restart;
  wire                 sys_pg_next;

  // Payload loss counts as a failure just like the explicit fault input
  assign fail = power_fail_i | ~payload_power_i; // R14

  // Interval restarts on every step and whenever the watched rail drops
  assign restart = (state_next != state_reg) | ~watch_pg; // R19

  ms_delay #(
    .CLKS_PER_MS (CLKS_PER_MS),
    .PRESCALE_W  (`SEQ_PRESCALE_W),
    .MS_W        (`SEQ_MS_W)
  ) u_delay (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .restart_i (restart),
    .target_i  (target),
    .done_o    (delay_done)
  );

  // Rail whose power good must hold, and the length of each wait
  always @* begin
    watch_pg = 1'b1;
    target   = `SEQ_T_STEP_MS;
    case (state_reg)
      S_AUX: begin
        watch_pg = aux_3v3_rail_pg_i; // R2
        target   = `SEQ_T_AUX_MS; // R2
      end
      S_R5V:   watch_pg = rail_5v_pg_i & rail_2v5_pg_i; // R3
      S_FCORE: watch_pg = fixed_core_rail_pg_i; // R5
      S_IO:    watch_pg = io_1v8_rail_pg_i; // R6
      S_MEM:   watch_pg = memory_1v5_rail_pg_i; // R8
      S_TERM:  watch_pg = termination_rail_pg_i & clkgen_pll_locked_i; // R9
      S_FULL:  target   = `SEQ_T_GPIO_MS; // R13
      default: watch_pg = 1'b1;
    endcase
  end

  // Step order; a failure anywhere in the powered sequence aborts it
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        // Start only with payload present and the aux 3.3 V rail good
        if (!fail && aux_3v3_rail_pg_i)
          state_next = S_AUX;
      end
      S_AUX: begin
        // Aux rail must have held good for the whole 10 ms
        if (delay_done)
          state_next = S_R5V;
      end
      S_R5V: begin
        // Both 5 V and 2.5 V good for 5 ms before the core rail
        if (delay_done)
          state_next = S_ACORE;
      end
      S_ACORE: begin
        // Plain 5 ms from the enable; no power good is watched here
        if (delay_done)
          state_next = S_FCORE; // R4
      end
      S_FCORE: begin
        // Fixed core good for 5 ms before the I/O rail
        if (delay_done)
          state_next = S_IO;
      end
      S_IO: begin
        // I/O rail good for 5 ms before unlocking and clock start
        if (delay_done)
          state_next = S_CLK;
      end
      S_CLK: begin
        // Clock generators get 5 ms to settle before memory power
        if (delay_done)
          state_next = S_MEM; // R7
      end
      S_MEM: begin
        // Memory rail good for 5 ms before termination
        if (delay_done)
          state_next = S_TERM;
      end
      S_TERM: begin
        // Termination good and PLLs locked together for 5 ms
        if (delay_done)
          state_next = S_WARM;
      end
      S_WARM: begin
        // Warm reset released; power-on reset follows after 5 ms
        if (delay_done)
          state_next = S_POR; // R11
      end
      S_POR: begin
        // Power-on reset released; full reset follows after 5 ms
        if (delay_done)
          state_next = S_FULL; // R12
      end
      S_FULL: begin
        // Boot pins stay driven for 1 ms after the full reset release
        if (delay_done)
          state_next = S_RUN;
      end
      // Running; only a failure leaves this state
      S_RUN:   state_next = S_RUN;
      S_PDRST: begin
        // Resets held 5 ms before the clocks are stopped
        if (delay_done)
          state_next = S_PDCLK; // R15
      end
      // Rails drop one cycle after the clocks stop
      S_PDCLK: state_next = S_PDOFF; // R16
      S_PDOFF: begin
        // Stay down until the failure has gone, then start over
        if (!fail)
          state_next = S_IDLE;
      end
      // Unreachable codes fall back to idle with everything off
      default: state_next = S_IDLE;
    endcase
    // Failure overrides any step of the powered sequence
    if (fail && (|state_reg[I_RUN:I_AUX]))
      state_next = S_PDRST; // R14
  end

  // State register; reset lands in idle with every rail off
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      state_reg <= S_IDLE;
    else
      state_reg <= state_next;
  end

  // Aux 3.3 V counts as monitored; the output lags by one flop
  assign sys_pg_next = aux_3v3_rail_pg_i & rail_5v_pg_i & rail_2v5_pg_i &
                       adaptive_core_rail_pg_i & fixed_core_rail_pg_i &
                       io_1v8_rail_pg_i & memory_1v5_rail_pg_i &
                       termination_rail_pg_i; // R18

  // Outputs decode from the next state so they change with the state
  // register; every one is a flop, so the pins never glitch on decode
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rail_5v_en_o            <= `SEQ_RST_RAIL_EN;
      rail_2v5_en_o           <= `SEQ_RST_RAIL_EN;
      adaptive_core_rail_en_o <= `SEQ_RST_RAIL_EN;
      fixed_core_rail_en_o    <= `SEQ_RST_RAIL_EN;
      io_1v8_rail_en_o        <= `SEQ_RST_RAIL_EN;
      memory_1v5_rail_en_o    <= `SEQ_RST_RAIL_EN;
      termination_rail_en_o   <= `SEQ_RST_RAIL_EN;
      outputs_1v8_unlocked_o  <= `SEQ_RST_UNLOCK;
      clkgen_powerdown_n_o    <= `SEQ_RST_RESET_N;
      warm_reset_n_o          <= `SEQ_RST_RESET_N;
      power_on_reset_n_o      <= `SEQ_RST_RESET_N;
      full_reset_n_o          <= `SEQ_RST_RESET_N;
      nmi_n_o                 <= `SEQ_RST_RESET_N;
      boot_cfg_o              <= {BOOT_W{1'b0}};
      boot_cfg_oe_n_o         <= `SEQ_RST_BOOT_OE_N;
      system_power_good_o     <= 1'b0;
      user_led_o              <= 4'h0;
      user_switch_o           <= 1'b0;
    end else begin
      // 5 V stays up through power-down; it drops only back in idle
      rail_5v_en_o            <= |state_next[I_PDOFF:I_R5V]; // R2
      rail_2v5_en_o           <= |state_next[I_PDCLK:I_R5V]; // R16
      adaptive_core_rail_en_o <= |state_next[I_PDCLK:I_ACORE]; // R3
      fixed_core_rail_en_o    <= |state_next[I_PDCLK:I_FCORE]; // R4
      io_1v8_rail_en_o        <= |state_next[I_PDCLK:I_IO]; // R5
      memory_1v5_rail_en_o    <= |state_next[I_PDCLK:I_MEM]; // R7
      termination_rail_en_o   <= |state_next[I_PDCLK:I_TERM]; // R8
      // Locked outputs sit at ground until unlocked
      outputs_1v8_unlocked_o  <= |state_next[I_PDRST:I_CLK]; // R6
      clkgen_powerdown_n_o    <= |state_next[I_PDRST:I_CLK]; // R15
      warm_reset_n_o          <= |state_next[I_PDRST:I_WARM]; // R9
      nmi_n_o                 <= |state_next[I_PDRST:I_WARM]; // R1
      power_on_reset_n_o      <= |state_next[I_RUN:I_POR]; // R14
      full_reset_n_o          <= |state_next[I_RUN:I_FULL]; // R12
      // Boot pins: held low while locked, driven with the configuration
      // from warm release until released, floating otherwise
      if (|state_next[I_FULL:I_WARM])
        boot_cfg_o <= boot_cfg_i; // R10
      else
        boot_cfg_o <= {BOOT_W{1'b0}}; // R1
      boot_cfg_oe_n_o <= ~(|state_next[I_IO:I_IDLE] |
                           |state_next[I_FULL:I_WARM] |
                           |state_next[I_PDOFF:I_PDCLK]); // R13
      system_power_good_o <= sys_pg_next; // R18
      user_led_o          <= user_led_i; // R17
      user_switch_o       <= user_switch_i; // R17
    end
  end

endmodule // power_reset_seq

// file: shared/seq_defs.vh
// Timing constants and output reset levels for the power and reset
// sequencer. Definitions only; included by the design files.
`ifndef SEQ_DEFS_VH
`define SEQ_DEFS_VH

// Sequencer clock rate in kHz, which is also the number of cycles per ms
`define SEQ_CLK_KHZ          250000
// Cycles in one millisecond, derived from the clock rate
`define SEQ_CLKS_PER_MS      (`SEQ_CLK_KHZ * 1)
// Width of the millisecond prescaler
`define SEQ_PRESCALE_W       18
// Width of the millisecond counter
`define SEQ_MS_W             4

// Intervals in milliseconds
`define SEQ_T_AUX_MS         4'hA
`define SEQ_T_STEP_MS        4'h5
`define SEQ_T_GPIO_MS        4'h1

// Reset levels of the outputs: every rail off, everything locked low
`define SEQ_RST_RAIL_EN      1'b0
`define SEQ_RST_RESET_N      1'b0
`define SEQ_RST_UNLOCK       1'b0
`define SEQ_RST_BOOT_OE_N    1'b0

`endif

// file: testbench/power_reset_seq_asserts.sv
// Checker for the power and reset sequencer: step delays and lock levels.
// Bound to the top module; CLKS_PER_MS is handed on by the bind.
`timescale 1ns/1ns
module power_reset_seq_asserts #(parameter CLKS_PER_MS = 4) (
  input wire sys_clk_i, rst_n_i, payload_power_i, power_fail_i,
  input wire aux_3v3_rail_pg_i, rail_5v_pg_i, rail_2v5_pg_i,
  input wire adaptive_core_rail_pg_i, fixed_core_rail_pg_i,
  input wire io_1v8_rail_pg_i, memory_1v5_rail_pg_i,
  input wire termination_rail_pg_i, clkgen_pll_locked_i, rail_5v_en_o,
  input wire rail_2v5_en_o, adaptive_core_rail_en_o, fixed_core_rail_en_o,
  input wire io_1v8_rail_en_o, memory_1v5_rail_en_o, termination_rail_en_o,
  input wire outputs_1v8_unlocked_o, clkgen_powerdown_n_o, warm_reset_n_o,
  input wire power_on_reset_n_o, full_reset_n_o, nmi_n_o,
  input wire boot_cfg_oe_n_o, system_power_good_o
);
  localparam int T1 = CLKS_PER_MS;
  localparam int T5 = 5 * CLKS_PER_MS;
  localparam int T10 = 10 * CLKS_PER_MS;
  wire all_pg = aux_3v3_rail_pg_i & rail_5v_pg_i & rail_2v5_pg_i &
    adaptive_core_rail_pg_i & fixed_core_rail_pg_i & io_1v8_rail_pg_i &
    memory_1v5_rail_pg_i & termination_rail_pg_i;
  wire [11:0] w = {!power_on_reset_n_o, full_reset_n_o, power_on_reset_n_o,
    warm_reset_n_o, termination_rail_pg_i & clkgen_pll_locked_i,
    memory_1v5_rail_pg_i, clkgen_powerdown_n_o, io_1v8_rail_pg_i,
    fixed_core_rail_pg_i, adaptive_core_rail_en_o,
    rail_5v_pg_i & rail_2v5_pg_i, aux_3v3_rail_pg_i};
  int c [12];
  // Cycles each watched level has held; a drop restarts the count
  always @(posedge sys_clk_i or negedge rst_n_i)
    for (int i = 0; i < 12; i++)
      c[i] <= !rst_n_i ? 0 : (w[i] ? c[i] + 1 : 0);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_locked_early: assert property (!io_1v8_rail_en_o |->
    !outputs_1v8_unlocked_o && !warm_reset_n_o && !nmi_n_o) else $error("lock");
  chk_aux_wait: assert property ($rose(rail_5v_en_o) |->
    rail_2v5_en_o && c[0] >= T10) else $error("aux wait");
  chk_core_wait: assert property ($rose(adaptive_core_rail_en_o) |->
    c[1] >= T5) else $error("core wait");
  chk_fixed_delay: assert property ($rose(fixed_core_rail_en_o) |->
    c[2] inside {[T5-1:T5+1]}) else $error("fixed delay");
  chk_io_wait: assert property ($rose(io_1v8_rail_en_o) |->
    c[3] >= T5) else $error("io wait");
  chk_clkgen_start: assert property ($rose(clkgen_powerdown_n_o) |->
    outputs_1v8_unlocked_o && c[4] >= T5) else $error("clkgen start");
  chk_mem_delay: assert property ($rose(memory_1v5_rail_en_o) |->
    c[5] inside {[T5-1:T5+1]}) else $error("mem delay");
  chk_term_wait: assert property ($rose(termination_rail_en_o) |->
    c[6] >= T5) else $error("term wait");
  chk_warm_release: assert property ($rose(warm_reset_n_o) |->
    nmi_n_o && !boot_cfg_oe_n_o && c[7] >= T5) else $error("warm");
  chk_por_delay: assert property ($rose(power_on_reset_n_o) |->
    c[8] inside {[T5-1:T5+1]}) else $error("por delay");
  chk_full_delay: assert property ($rose(full_reset_n_o) |->
    c[9] inside {[T5-1:T5+1]}) else $error("full delay");
  chk_boot_release: assert property ($rose(boot_cfg_oe_n_o) &&
    full_reset_n_o |-> c[10] inside {[T1-1:T1+1]}) else $error("boot");
  chk_fail_resets: assert property ((power_fail_i || !payload_power_i) &&
    full_reset_n_o |=> !full_reset_n_o && !power_on_reset_n_o)
    else $error("fail resets");
  chk_clk_stop: assert property ($fell(clkgen_powerdown_n_o) |->
    !outputs_1v8_unlocked_o && c[11] inside {[T5-1:T5+1]}) else $error("stop");
  chk_rails_off: assert property ($fell(io_1v8_rail_en_o) |->
    !adaptive_core_rail_en_o && !fixed_core_rail_en_o && !rail_2v5_en_o &&
    !memory_1v5_rail_en_o && !termination_rail_en_o) else $error("rails");
  chk_power_good: assert property ($past(rst_n_i) |->
    system_power_good_o == $past(all_pg)) else $error("power good");
endmodule // power_reset_seq_asserts

bind power_reset_seq power_reset_seq_asserts
  #(.CLKS_PER_MS(CLKS_PER_MS)) i_power_reset_seq_asserts (.*);

// file: testbench/rail_model.sv
// Regulators and clock generators seen from the sequencer's pins.
// Power good trails each enable by two cycles; drop_i glitches fixed core.
`timescale 1ns/1ns
module rail_model (
  input  wire       sys_clk_i,
  input  wire [6:0] en_i,
  input  wire       pd_n_i,
  input  wire       drop_i,
  output reg  [6:0] pg_o,
  output reg        lock_o
);
  reg [6:0] dly = 7'h00;
  reg       pd_d = 1'b0;
  // Ramp lag; a rail switched off loses its power good one cycle later
  always @(posedge sys_clk_i) begin
    dly    <= en_i;
    pg_o   <= dly & en_i & ~{3'h0, drop_i, 3'h0};
    pd_d   <= pd_n_i;
    lock_o <= pd_d & pd_n_i;
  end
endmodule // rail_model

// file: testbench/test_power_reset_seq.sv
// Self-checking bench: two power-up runs against an interval table,
// shut down by power failure and then by payload loss.
`timescale 1ns/1ns
module test_power_reset_seq;
  localparam int C = 4;
  logic sys_clk_i = 0, rst_n_i = 0, payload_power_i = 0, power_fail_i = 0;
  logic aux_3v3_rail_pg_i = 0, user_switch_i = 0, drop = 0;
  logic [15:0] boot_cfg_i = 16'h0000;
  logic [3:0] user_led_i = 4'h0;
  wire rail_5v_pg_i, rail_2v5_pg_i, adaptive_core_rail_pg_i, io_1v8_rail_pg_i;
  wire fixed_core_rail_pg_i, memory_1v5_rail_pg_i, termination_rail_pg_i;
  wire clkgen_pll_locked_i, rail_5v_en_o, rail_2v5_en_o, io_1v8_rail_en_o;
  wire adaptive_core_rail_en_o, fixed_core_rail_en_o, memory_1v5_rail_en_o;
  wire termination_rail_en_o, outputs_1v8_unlocked_o, clkgen_powerdown_n_o;
  wire warm_reset_n_o, power_on_reset_n_o, full_reset_n_o, nmi_n_o;
  wire boot_cfg_oe_n_o, system_power_good_o, user_switch_o;
  wire [15:0] boot_cfg_o;
  wire [3:0] user_led_o;
  wire [10:0] ev = {boot_cfg_oe_n_o, full_reset_n_o, power_on_reset_n_o,
    warm_reset_n_o, termination_rail_en_o, memory_1v5_rail_en_o,
    clkgen_powerdown_n_o, io_1v8_rail_en_o, fixed_core_rail_en_o,
    adaptive_core_rail_en_o, rail_5v_en_o};
  // Expected cycles between step edges: delay, plus two cycles of ramp lag where a rail_model power good is watched
  int gap [11] = '{10*C, 5*C+2, 5*C, 5*C+2, 5*C+2, 5*C, 5*C+2, 5*C+2,
    5*C, 5*C, C};
  int error_cnt = 0, cmp_count = 0;

  power_reset_seq #(.CLKS_PER_MS(C)) i_power_reset_seq (.*);
  rail_model i_rail_model (.sys_clk_i(sys_clk_i), .pd_n_i(clkgen_powerdown_n_o),
    .en_i({termination_rail_en_o, memory_1v5_rail_en_o, io_1v8_rail_en_o,
      fixed_core_rail_en_o, adaptive_core_rail_en_o, rail_2v5_en_o,
      rail_5v_en_o}), .drop_i(drop), .lock_o(clkgen_pll_locked_i),
    .pg_o({termination_rail_pg_i, memory_1v5_rail_pg_i, io_1v8_rail_pg_i,
      fixed_core_rail_pg_i, adaptive_core_rail_pg_i, rail_2v5_pg_i,
      rail_5v_pg_i}));

  always #2 sys_clk_i = ~sys_clk_i;

  task automatic print_verdict;
    if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic cmp(logic [15:0] got, logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t level %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_gap(int n, int exp);
    cmp_count++;
    if (n < exp - 1 || n > exp + 2) begin
      error_cnt++;
      $display("[FAIL] %0t interval %0d expected %0d", $time, n, exp);
    end
  endtask

  // Count falling edges until a step level shows; pulse drop at cycle dr
  task automatic step(int b, logic lvl, int exp, int dr);
    int n;
    n = 0;
    while (ev[b] !== lvl && n < 1000) begin
      @(negedge sys_clk_i);
      n++;
      drop = (n == dr);
    end
    cmp_gap(n, exp);
  endtask

  initial begin
    void'($urandom(12443));
    repeat (2) @(negedge sys_clk_i);
    rst_n_i = 1;
    for (int r = 0; r < 2; r++) begin
      boot_cfg_i = 16'($urandom);
      payload_power_i = 1;
      aux_3v3_rail_pg_i = 1;
      for (int i = 0; i < 11; i++) begin
        step(i, 1, gap[i] + (r && i == 3 ? 2*C : 0), r && i == 3 ? 2*C : -1);
        if (i == 0) cmp(rail_2v5_en_o, 1);
        if (i == 4) cmp(outputs_1v8_unlocked_o, 1);
        if (i == 7) cmp(boot_cfg_o, boot_cfg_i);
        if (i == 7) cmp(nmi_n_o, 1);
      end
      cmp(system_power_good_o, 1);
      if (r) payload_power_i = 0;
      else power_fail_i = 1;
      @(negedge sys_clk_i);
      cmp({full_reset_n_o, power_on_reset_n_o, warm_reset_n_o}, 3'h1);
      step(4, 0, 5*C, -1);
      @(negedge sys_clk_i);
      cmp({io_1v8_rail_en_o, rail_2v5_en_o, rail_5v_en_o}, 3'h1);
      // Payload back and aux gone: 5 V drops in idle, no restart
      power_fail_i = 0;
      payload_power_i = 1;
      aux_3v3_rail_pg_i = 0;
      repeat (3) @(negedge sys_clk_i);
      cmp(rail_5v_en_o, 0);
      cmp(system_power_good_o, 0);
    end
    // Software LED and switch levels pass through one flop
    repeat (4) begin
      user_led_i = 4'($urandom);
      user_switch_i = 1'($urandom);
      @(negedge sys_clk_i);
      cmp({user_led_o, user_switch_o}, {user_led_i, user_switch_i});
    end
    print_verdict();
  end

  // Watchdog well beyond the two runs
  initial begin
    #80000;
    error_cnt++;
    print_verdict();
  end
endmodule // test_power_reset_seq
